// file: logic/pdla_actuator.sv
`timescale 1ns/1ps
`default_nettype none
module pdla_actuator (
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    input  wire logic                  inValid,
    input  wire logic signed [15:0]    inI,
    input  wire logic signed [15:0]    inQ,
    input  wire logic                  predistortionEnable,
    input  wire logic                  tableEntryCountSelect,
    input  wire logic                  customOrderSelect,
    input  wire logic [3:0][7:0]       tapTermBitmaps,
    input  wire logic [3:0]            magnitudePrescale,
    input  wire logic                  prescaleWrEn,
    input  wire logic                  coefWrEn,
    input  wire logic [1:0]            coefWrTap,
    input  wire logic [2:0]            coefWrOrder,
    input  wire logic [15:0]           coefWrI,
    input  wire logic [15:0]           coefWrQ,
    input  wire logic                  tableRebuild,
    output logic                       outValid,
    output logic signed [15:0]         outI,
    output logic signed [15:0]         outQ,
    output logic                       tableBusy,
    output logic [3:0]                 prescaleActive
);
    localparam int NT = pdla_pkg::NUM_TAPS;
    localparam int GW = pdla_pkg::GAIN_W;

    pdla_build_if bif ();

    // Coefficient store, one complex word per tap and order
    logic [NT-1:0][7:0][GW-1:0] coefI_r;
    logic [NT-1:0][7:0][GW-1:0] coefQ_r;

    // Gain tables, always sized for the larger choice
    logic [GW-1:0] lutI_r [NT][pdla_pkg::MAX_ENTRIES];
    logic [GW-1:0] lutQ_r [NT][pdla_pkg::MAX_ENTRIES];

    logic [3:0]                  prescale_r;
    logic signed [15:0]          dly1I_r;
    logic signed [15:0]          dly1Q_r;
    logic signed [15:0]          dly2I_r;
    logic signed [15:0]          dly2Q_r;
    logic [pdla_pkg::INDEX_W-1:0] idx1_r;
    logic [pdla_pkg::INDEX_W-1:0] idx2_r;

    logic signed [GW-1:0] gainI_r [NT];
    logic signed [GW-1:0] gainQ_r [NT];
    logic signed [15:0]   dataI_r [NT];
    logic signed [15:0]   dataQ_r [NT];
    logic                 stageValid_r;
    logic                 stageEnable_r;

    logic                 outValid_r;
    logic signed [15:0]   outI_r;
    logic signed [15:0]   outQ_r;
    logic                 tableBusy_r;

    // Magnitude estimate max + 3/8 min, cheap and within a few percent
    function automatic logic [pdla_pkg::INDEX_W-1:0] mag_index(
        input logic signed [15:0] si,
        input logic signed [15:0] sq,
        input logic [3:0]         ps,
        input logic               big
    );
        logic [15:0] ai;
        logic [15:0] aq;
        logic [15:0] mx;
        logic [15:0] mn;
        logic [16:0] mag;
        logic [20:0] scaled;
        ai = si[15] ? 16'(-si) : 16'(si);
        aq = sq[15] ? 16'(-sq) : 16'(sq);
        mx = (ai > aq) ? ai : aq;
        mn = (ai > aq) ? aq : ai;
        mag = {1'b0, mx} + 17'(mn >> 2) + 17'(mn >> 3);
        scaled = (21'(mag) * 21'(ps)) >> pdla_pkg::PRESCALE_FRAC;
        if (scaled >= pdla_pkg::FULL_SCALE)
            return big ? pdla_pkg::LAST_BIG : pdla_pkg::LAST_SMALL;
        else if (big)
            return scaled[pdla_pkg::MAG_FRAC-1 -: pdla_pkg::INDEX_W];
        else
            return {1'b0, scaled[pdla_pkg::MAG_FRAC-1 -: pdla_pkg::INDEX_W-1]};
    endfunction

    wire [pdla_pkg::INDEX_W-1:0] idxNow =
        mag_index(inI, inQ, prescale_r, tableEntryCountSelect);

    // Effective bitmaps feed the builder
    wire [NT-1:0][7:0] effBitmaps =
        customOrderSelect ? tapTermBitmaps : pdla_pkg::DEFAULT_BITMAPS;

    assign bif.start   = tableRebuild;
    assign bif.sizeSel = tableEntryCountSelect;
    assign bif.bitmaps = effBitmaps;
    assign bif.coefI   = coefI_r;
    assign bif.coefQ   = coefQ_r;

    pdla_table_builder u_builder (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bif     (bif)
    );

    // History taps: index 0 is the sample arriving now
    wire signed [15:0]            histI   [3];
    wire signed [15:0]            histQ   [3];
    wire [pdla_pkg::INDEX_W-1:0]  histIdx [3];

    assign histI[0]   = inI;
    assign histQ[0]   = inQ;
    assign histIdx[0] = idxNow;
    assign histI[1]   = dly1I_r;
    assign histQ[1]   = dly1Q_r;
    assign histIdx[1] = idx1_r;
    assign histI[2]   = dly2I_r;
    assign histQ[2]   = dly2Q_r;
    assign histIdx[2] = idx2_r;

    wire signed [GW-1:0] lookI [NT];
    wire signed [GW-1:0] lookQ [NT];
    wire signed [15:0]   selI  [NT];
    wire signed [15:0]   selQ  [NT];
    wire signed [32:0]   prodRe [NT];
    wire signed [32:0]   prodIm [NT];

    genvar t;
    generate
        for (t = 0; t < NT; t++)
        begin : g_tap
            // Each tap reads its own table at its own magnitude delay
            assign lookI[t] = lutI_r[t][histIdx[pdla_pkg::TAP_MAG_DELAY[t]]];
            assign lookQ[t] = lutQ_r[t][histIdx[pdla_pkg::TAP_MAG_DELAY[t]]];
            assign selI[t]  = histI[pdla_pkg::TAP_DATA_DELAY[t]];
            assign selQ[t]  = histQ[pdla_pkg::TAP_DATA_DELAY[t]];
            assign prodRe[t] = gainI_r[t] * dataI_r[t] - gainQ_r[t] * dataQ_r[t];
            assign prodIm[t] = gainI_r[t] * dataQ_r[t] + gainQ_r[t] * dataI_r[t];
        end
    endgenerate

    logic signed [34:0] sumRe;
    logic signed [34:0] sumIm;

    always_comb
    begin
        sumRe = '0;
        sumIm = '0;
        for (int k = 0; k < NT; k++)
        begin
            sumRe = sumRe + 35'(prodRe[k]);
            sumIm = sumIm + 35'(prodIm[k]);
        end
    end

    wire signed [15:0] pdRe = pdla_pkg::sat_gain(40'(sumRe >>> pdla_pkg::GAIN_FRAC));
    wire signed [15:0] pdIm = pdla_pkg::sat_gain(40'(sumIm >>> pdla_pkg::GAIN_FRAC));

    // Bypass keeps the same latency so enabling never shifts timing
    wire signed [15:0] outI_nxt = stageEnable_r ? pdRe : dataI_r[0];
    wire signed [15:0] outQ_nxt = stageEnable_r ? pdIm : dataQ_r[0];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prescale_r <= pdla_pkg::PRESCALE_RESET;
        else if (prescaleWrEn)
            prescale_r <= magnitudePrescale;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            coefI_r <= '0;
            coefQ_r <= '0;
        end
        else if (coefWrEn)
        begin
            coefI_r[coefWrTap][coefWrOrder] <= coefWrI;
            coefQ_r[coefWrTap][coefWrOrder] <= coefWrQ;
        end
    end

    // Tables start at unity on all four taps, so before the first build the output sums every tap's delayed sample
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < NT; k++)
            begin
                for (int e = 0; e < pdla_pkg::MAX_ENTRIES; e++)
                begin
                    lutI_r[k][e] <= pdla_pkg::UNITY_GAIN;
                    lutQ_r[k][e] <= '0;
                end
            end
        end
        else if (bif.wrEn)
        begin
            lutI_r[bif.wrTap][bif.wrAddr] <= bif.wrI;
            lutQ_r[bif.wrTap][bif.wrAddr] <= bif.wrQ;
        end
    end

    // Sample history advances only on valid samples
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            dly1I_r <= '0;
            dly1Q_r <= '0;
            dly2I_r <= '0;
            dly2Q_r <= '0;
            idx1_r  <= '0;
            idx2_r  <= '0;
        end
        else if (inValid)
        begin
            dly1I_r <= inI;
            dly1Q_r <= inQ;
            dly2I_r <= dly1I_r;
            dly2Q_r <= dly1Q_r;
            idx1_r  <= idxNow;
            idx2_r  <= idx1_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            for (int k = 0; k < NT; k++)
            begin
                gainI_r[k] <= '0;
                gainQ_r[k] <= '0;
                dataI_r[k] <= '0;
                dataQ_r[k] <= '0;
            end
        end
        else if (inValid)
        begin
            for (int k = 0; k < NT; k++)
            begin
                gainI_r[k] <= lookI[k];
                gainQ_r[k] <= lookQ[k];
                dataI_r[k] <= selI[k];
                dataQ_r[k] <= selQ[k];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            stageValid_r  <= 1'b0;
            stageEnable_r <= 1'b0;
        end
        else
        begin
            stageValid_r <= inValid;
            if (inValid)
                stageEnable_r <= predistortionEnable;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            outValid_r  <= 1'b0;
            outI_r      <= '0;
            outQ_r      <= '0;
            tableBusy_r <= 1'b0;
        end
        else
        begin
            outValid_r  <= stageValid_r;
            tableBusy_r <= bif.busy | tableRebuild;
            if (stageValid_r)
            begin
                outI_r <= outI_nxt;
                outQ_r <= outQ_nxt;
            end
        end
    end

    assign outValid       = outValid_r;
    assign outI           = outI_r;
    assign outQ           = outQ_r;
    assign tableBusy      = tableBusy_r;
    assign prescaleActive = prescale_r;
endmodule
`default_nettype wire

// file: logic/pdla_pkg.sv
// Notes on behaviour
// - Table holds 256 or 512 entries per tap; select picks bin count.
// - Exactly four taps, each with its own complex gain table.
// - Data/magnitude delays: tap0 0/0, tap1 1/1, tap2 2/2, tap3 1/2.
// - Output sums each tap gain times its delayed sample.
// - Each tap has an eight-bit term bitmap, orders zero to seven.
// - Bit zero is constant term; cleared bit drops that power term.
// - Default bitmaps 0x1F, 0x7F, 0x1F, 0x1E for taps zero to three.
// - Custom select uses supplied bitmaps, otherwise the defaults.
// - Magnitude times U2.2 prescale before indexing the tables.
// - Prescale reads 2.0 after reset.
// - Disabled means bypass; enabled applies current tables to every sample.
`default_nettype none
package pdla_pkg;
    localparam int SAMPLE_W  = 16;
    localparam int GAIN_W    = 16;
    localparam int GAIN_FRAC = 14;
    localparam int MAG_FRAC  = 15;
    localparam int NUM_TAPS  = 4;
    localparam int NUM_ORDS  = 8;
    localparam int INDEX_W   = 9;
    localparam int MAX_ENTRIES = 512;
    localparam int PRESCALE_FRAC = 2;

    localparam logic [3:0] PRESCALE_RESET = 4'h8;
    localparam logic [NUM_TAPS-1:0][7:0] DEFAULT_BITMAPS = {8'h1E, 8'h1F, 8'h7F, 8'h1F};
    localparam logic [NUM_TAPS-1:0][1:0] TAP_DATA_DELAY = {2'h1, 2'h2, 2'h1, 2'h0};
    localparam logic [NUM_TAPS-1:0][1:0] TAP_MAG_DELAY  = {2'h2, 2'h2, 2'h1, 2'h0};
    localparam logic [GAIN_W-1:0] UNITY_GAIN = 16'h4000;
    localparam logic [20:0] FULL_SCALE = 21'h008000;
    localparam logic [INDEX_W-1:0] LAST_BIG   = 9'h1FF;
    localparam logic [INDEX_W-1:0] LAST_SMALL = 9'h0FF;
    localparam logic [5:0] BIN_HALF_BIG   = 6'h20;
    localparam logic [6:0] BIN_HALF_SMALL = 7'h40;
    localparam logic signed [39:0] SAT_HI = 40'sh00_0000_7FFF;
    localparam logic signed [39:0] SAT_LO = 40'shFF_FFFF_8000;

    typedef enum logic [1:0] {
        PDLA_IDLE  = 2'h0,
        PDLA_EVAL  = 2'h1,
        PDLA_STORE = 2'h3
    } pdla_state_t;

    function automatic logic signed [GAIN_W-1:0] sat_gain(input logic signed [39:0] v);
        if (v > SAT_HI)
            return 16'h7FFF;
        else if (v < SAT_LO)
            return 16'h8000;
        else
            return v[GAIN_W-1:0];
    endfunction
endpackage
`default_nettype wire

// file: logic/pdla_build_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdla_build_if;
    logic                                                  start;
    logic                                                  busy;
    logic                                                  sizeSel;
    logic [pdla_pkg::NUM_TAPS-1:0][7:0]                    bitmaps;
    logic [pdla_pkg::NUM_TAPS-1:0][7:0][pdla_pkg::GAIN_W-1:0] coefI;
    logic [pdla_pkg::NUM_TAPS-1:0][7:0][pdla_pkg::GAIN_W-1:0] coefQ;
    logic                                                  wrEn;
    logic [1:0]                                            wrTap;
    logic [pdla_pkg::INDEX_W-1:0]                          wrAddr;
    logic [pdla_pkg::GAIN_W-1:0]                           wrI;
    logic [pdla_pkg::GAIN_W-1:0]                           wrQ;

    modport table_side (output start, sizeSel, bitmaps, coefI, coefQ,
                        input busy, wrEn, wrTap, wrAddr, wrI, wrQ);
    modport builder (input start, sizeSel, bitmaps, coefI, coefQ,
                     output busy, wrEn, wrTap, wrAddr, wrI, wrQ);
endinterface
`default_nettype wire

// file: logic/pdla_table_builder.sv
`timescale 1ns/1ps
`default_nettype none
// Fills the first 256 or all 512 entries of each tap table with its tap polynomial at the bin centre.
module pdla_table_builder (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    pdla_build_if.builder    bif
);
    pdla_pkg::pdla_state_t       state_r;
    logic [1:0]                  tap_r;
    logic [pdla_pkg::INDEX_W-1:0] bin_r;
    logic [2:0]                  ord_r;
    logic signed [15:0]          accI_r;
    logic signed [15:0]          accQ_r;
    logic                        busy_r;

    wire        useTerm = bif.bitmaps[tap_r][ord_r];
    wire [15:0] xVal    = bif.sizeSel ? {1'b0, bin_r, pdla_pkg::BIN_HALF_BIG}
                                      : {1'b0, bin_r[7:0], pdla_pkg::BIN_HALF_SMALL};
    wire signed [32:0] prodI = accI_r * $signed({1'b0, xVal});
    wire signed [32:0] prodQ = accQ_r * $signed({1'b0, xVal});
    wire signed [15:0] termI = useTerm ? $signed(bif.coefI[tap_r][ord_r]) : 16'sh0000;
    wire signed [15:0] termQ = useTerm ? $signed(bif.coefQ[tap_r][ord_r]) : 16'sh0000;
    wire signed [15:0] accI_nxt = pdla_pkg::sat_gain(40'(prodI >>> pdla_pkg::MAG_FRAC) + 40'(termI));
    wire signed [15:0] accQ_nxt = pdla_pkg::sat_gain(40'(prodQ >>> pdla_pkg::MAG_FRAC) + 40'(termQ));
    wire        lastBin = bin_r == (bif.sizeSel ? pdla_pkg::LAST_BIG : pdla_pkg::LAST_SMALL);

    assign bif.busy   = busy_r;
    assign bif.wrEn   = state_r == pdla_pkg::PDLA_STORE;
    assign bif.wrTap  = tap_r;
    assign bif.wrAddr = bin_r;
    assign bif.wrI    = accI_r;
    assign bif.wrQ    = accQ_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r <= pdla_pkg::PDLA_IDLE;
            tap_r   <= 2'h0;
            bin_r   <= '0;
            ord_r   <= 3'h7;
            accI_r  <= 16'sh0000;
            accQ_r  <= 16'sh0000;
            busy_r  <= 1'b0;
        end
        else
        begin
            case (state_r)
                pdla_pkg::PDLA_IDLE:
                begin
                    if (bif.start)
                    begin
                        state_r <= pdla_pkg::PDLA_EVAL;
                        busy_r  <= 1'b1;
                        tap_r   <= 2'h0;
                        bin_r   <= '0;
                        ord_r   <= 3'h7;
                        accI_r  <= 16'sh0000;
                        accQ_r  <= 16'sh0000;
                    end
                end
                pdla_pkg::PDLA_EVAL:
                begin
                    // Horner step, highest order first
                    accI_r <= accI_nxt;
                    accQ_r <= accQ_nxt;
                    ord_r  <= ord_r - 3'h1;
                    if (ord_r == 3'h0)
                        state_r <= pdla_pkg::PDLA_STORE;
                end
                pdla_pkg::PDLA_STORE:
                begin
                    accI_r  <= 16'sh0000;
                    accQ_r  <= 16'sh0000;
                    ord_r   <= 3'h7;
                    state_r <= pdla_pkg::PDLA_EVAL;
                    bin_r   <= bin_r + 9'h001;
                    if (lastBin)
                    begin
                        bin_r <= '0;
                        tap_r <= tap_r + 2'h1;
                        if (tap_r == 2'h3)
                        begin
                            state_r <= pdla_pkg::PDLA_IDLE;
                            busy_r  <= 1'b0;
                        end
                    end
                end
                default:
                    state_r <= pdla_pkg::PDLA_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: dv/pdla_stream_src.sv
`timescale 1ns/1ps
`default_nettype none
module pdla_stream_src (
    input  wire logic               clk_sys,
    output var logic                inValid,
    output var logic signed [15:0]  inI,
    output var logic signed [15:0]  inQ
);
    initial
    begin
        inValid = 1'b0;
        inI     = 16'h0000;
        inQ     = 16'h0000;
    end

    // Back to back when called on consecutive edges
    task automatic send(input logic signed [15:0] i, input logic signed [15:0] q);
        @(posedge clk_sys);
        inValid <= 1'b1;
        inI     <= i;
        inQ     <= q;
    endtask

    // Stale data inverted so an ignored valid cannot pass by luck
    task automatic idle();
        @(posedge clk_sys);
        inValid <= 1'b0;
        inI     <= ~inI;
        inQ     <= ~inQ;
    endtask
endmodule
`default_nettype wire

// file: dv/pdla_actuator_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pdla_actuator_chk (
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic               inValid,
    input wire logic signed [15:0] inI,
    input wire logic signed [15:0] inQ,
    input wire logic               predistortionEnable,
    input wire logic               tableEntryCountSelect,
    input wire logic [3:0]         magnitudePrescale,
    input wire logic               prescaleWrEn,
    input wire logic               tableRebuild,
    input wire logic               outValid,
    input wire logic signed [15:0] outI,
    input wire logic signed [15:0] outQ,
    input wire logic               tableBusy,
    input wire logic [3:0]         prescaleActive
);
    localparam int FILL_SMALL = 9216;
    localparam int FILL_BIG   = 18432;
    localparam int FILL_SLACK = 4;

    logic [15:0] busyCnt_r;
    logic [15:0] busyCnt_nxt;
    logic [31:0] fillLen;

    assign busyCnt_nxt = tableBusy ? busyCnt_r + 16'h0001 : 16'h0000;
    assign fillLen     = tableEntryCountSelect ? FILL_BIG : FILL_SMALL;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            busyCnt_r <= 16'h0000;
        else
            busyCnt_r <= busyCnt_nxt;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence seqRebuildTaken;
        tableRebuild && !tableBusy;
    endsequence
    sequence seqFillRunning;
        tableBusy [*8];
    endsequence
    sequence seqBypassTaken;
        inValid && !predistortionEnable;
    endsequence

    chk_out_latency: assert property (inValid |-> ##2 outValid)
        else $error("output valid missing two cycles after a sample");
    chk_no_spurious: assert property (outValid |-> $past(inValid, 2))
        else $error("output valid without a sample two cycles before");
    chk_bypass_pass: assert property (seqBypassTaken |-> ##2 (outI == $past(inI, 2) && outQ == $past(inQ, 2)))
        else $error("bypass output differs from input sample");
    chk_out_hold: assert property (!outValid |-> $stable(outI) && $stable(outQ))
        else $error("output sample changed without output valid");
    chk_fill_start: assert property (seqRebuildTaken |=> seqFillRunning)
        else $error("table fill did not start after rebuild");
    chk_fill_length: assert property ($fell(tableBusy) |-> busyCnt_r >= fillLen && busyCnt_r <= fillLen + FILL_SLACK)
        else $error("table fill length wrong for table size");
    chk_prescale_reset: assert property (disable iff (1'b0) rst |=> prescaleActive == 4'h8)
        else $error("prescale not two after reset");
    chk_prescale_load: assert property (prescaleWrEn |=> prescaleActive == $past(magnitudePrescale))
        else $error("prescale write not taken");
    chk_prescale_hold: assert property (!prescaleWrEn |=> $stable(prescaleActive))
        else $error("prescale changed without a write");
endmodule

bind pdla_actuator pdla_actuator_chk u_chk (.*);
`default_nettype wire

// file: dv/tb_predistortion_lut_actuator.sv
`timescale 1ns/1ps
`default_nettype none
module tb_predistortion_lut_actuator;
    logic               clk_sys;
    logic               rst;
    logic               inValid;
    logic signed [15:0] inI;
    logic signed [15:0] inQ;
    logic               predistortionEnable;
    logic               tableEntryCountSelect;
    logic               customOrderSelect;
    logic [3:0][7:0]    tapTermBitmaps;
    logic [3:0]         magnitudePrescale;
    logic               prescaleWrEn;
    logic               coefWrEn;
    logic [1:0]         coefWrTap;
    logic [2:0]         coefWrOrder;
    logic [15:0]        coefWrI;
    logic [15:0]        coefWrQ;
    logic               tableRebuild;
    logic               outValid;
    logic signed [15:0] outI;
    logic signed [15:0] outQ;
    logic               tableBusy;
    logic [3:0]         prescaleActive;
    int                 errCount;
    int                 checksDone;
    logic               built;
    logic               bigB;
    logic [3:0][7:0]    bmB;
    logic [3:0]         psModel;
    int                 ix0;
    int                 hisIx [2];
    logic signed [15:0] hisI [2];
    logic signed [15:0] hisQ [2];
    logic [31:0]        expQ [$];
    logic [31:0]        expHead;
    logic [15:0]        eI;
    logic [15:0]        eQ;

    pdla_stream_src u_src (.clk_sys(clk_sys), .inValid(inValid), .inI(inI), .inQ(inQ));

    pdla_actuator u_dut (
        .clk_sys(clk_sys), .rst(rst), .inValid(inValid), .inI(inI), .inQ(inQ),
        .predistortionEnable(predistortionEnable), .tableEntryCountSelect(tableEntryCountSelect),
        .customOrderSelect(customOrderSelect), .tapTermBitmaps(tapTermBitmaps),
        .magnitudePrescale(magnitudePrescale), .prescaleWrEn(prescaleWrEn), .coefWrEn(coefWrEn),
        .coefWrTap(coefWrTap), .coefWrOrder(coefWrOrder), .coefWrI(coefWrI), .coefWrQ(coefWrQ),
        .tableRebuild(tableRebuild), .outValid(outValid), .outI(outI), .outQ(outQ),
        .tableBusy(tableBusy), .prescaleActive(prescaleActive)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    function automatic int idx_of(input logic signed [15:0] i, input logic signed [15:0] q,
                                  input logic [3:0] ps, input logic big);
        int a;
        int b;
        int sc;
        a = (i < 0) ? -int'(i) : int'(i);
        b = (q < 0) ? -int'(q) : int'(q);
        sc = (((a > b) ? a : b) + (((a > b) ? b : a) >> 2) + (((a > b) ? b : a) >> 3)) * int'(ps);
        sc = sc >> 2;
        if (sc >= 32'h8000)
            return big ? 32'h1FF : 32'h0FF;
        return big ? sc >> 6 : sc >> 7;
    endfunction

    // Only orders 0 and 1 carry coefficients, so a gain is 1, x, 1+x or 0
    function automatic int gain(input int t, input int ix);
        int c;
        c = bigB ? ix * 32 + 16 : ix * 64 + 32;
        if (!built)
            return 32'h4000;
        return (bmB[t][0] ? 32'h4000 : 0) + (((t == 0 || t == 3) && bmB[t][1]) ? c : 0);
    endfunction

    function automatic logic [15:0] sat(input longint v);
        v = v >>> 14;
        if (v > 32'sh7FFF)
            return 16'h7FFF;
        if (v < -32'sh8000)
            return 16'h8000;
        return v[15:0];
    endfunction

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp)
        begin
            errCount++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk_sys)
    begin
        if (!rst && inValid)
        begin
            ix0 = idx_of(inI, inQ, psModel, tableEntryCountSelect);
            eI = inI;
            eQ = inQ;
            if (predistortionEnable)
            begin
                eI = sat(gain(0, ix0) * longint'(inI) + (gain(1, hisIx[0]) + gain(3, hisIx[1])) * longint'(hisI[0])
                         + gain(2, hisIx[1]) * longint'(hisI[1]));
                eQ = sat(gain(0, ix0) * longint'(inQ) + (gain(1, hisIx[0]) + gain(3, hisIx[1])) * longint'(hisQ[0])
                         + gain(2, hisIx[1]) * longint'(hisQ[1]));
            end
            expQ.push_back({eI, eQ});
            hisIx[1] = hisIx[0];
            hisIx[0] = ix0;
            hisI[1] = hisI[0];
            hisI[0] = inI;
            hisQ[1] = hisQ[0];
            hisQ[0] = inQ;
        end
        if (outValid && expQ.size() == 0)
            check_val(outI, 16'hDEAD);
        else if (outValid)
        begin
            expHead = expQ.pop_front();
            check_val(outI, expHead[31:16]);
            check_val(outQ, expHead[15:0]);
        end
    end

    task automatic write_prescale(input logic [3:0] v);
        @(posedge clk_sys);
        magnitudePrescale <= v;
        prescaleWrEn <= 1'b1;
        @(posedge clk_sys);
        prescaleWrEn <= 1'b0;
        psModel = v;
        @(posedge clk_sys);
        #1;
        check_val({12'h000, prescaleActive}, {12'h000, v});
    endtask

    // A second request mid-fill must be ignored, so the length stays single
    task automatic rebuild(input logic big, input logic cust);
        int n;
        int fill;
        fill = big ? 32'h4800 : 32'h2400;
        @(posedge clk_sys);
        tableEntryCountSelect <= big;
        customOrderSelect <= cust;
        tableRebuild <= 1'b1;
        @(posedge clk_sys);
        tableRebuild <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            #1;
            n++;
            tableRebuild <= (n == 3);
        end
        while (tableBusy === 1'b1 && n < 32'h4E20);
        check_val({15'h0000, n >= fill && n <= fill + 4}, 16'h0001);
        built = 1'b1;
        bigB = big;
        bmB = cust ? tapTermBitmaps : {8'h1E, 8'h1F, 8'h7F, 8'h1F};
    endtask

    // Gap at k=7 shows history counts only valid samples
    task automatic sweep();
        for (int k = 0; k < 16; k++)
        begin
            if (k == 7)
                u_src.idle();
            u_src.send(16'(k * 16'h1111), 16'(-k * 16'h0321));
        end
        u_src.idle();
        repeat (3) @(posedge clk_sys);
    endtask

    initial
    begin
        rst = 1'b1;
        predistortionEnable = 1'b0;
        tableEntryCountSelect = 1'b0;
        customOrderSelect = 1'b0;
        tapTermBitmaps = {8'h00, 8'h03, 8'h1F, 8'h03};
        magnitudePrescale = 4'h8;
        prescaleWrEn = 1'b0;
        coefWrEn = 1'b0;
        coefWrTap = 2'h0;
        coefWrOrder = 3'h0;
        coefWrI = 16'h0000;
        coefWrQ = 16'h0000;
        tableRebuild = 1'b0;
        errCount = 0;
        checksDone = 0;
        built = 1'b0;
        bigB = 1'b0;
        bmB = '0;
        psModel = 4'h8;
        hisIx = '{0, 0};
        hisI = '{16'h0000, 16'h0000};
        hisQ = '{16'h0000, 16'h0000};
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        check_val({12'h000, prescaleActive}, 16'h0008);
        check_val({14'h0000, outValid, tableBusy}, 16'h0000);
        predistortionEnable <= 1'b1;
        sweep();
        for (int t = 0; t < 6; t++)
        begin
            @(posedge clk_sys);
            coefWrEn <= 1'b1;
            coefWrTap <= (t < 4) ? 2'(t) : ((t == 4) ? 2'h0 : 2'h3);
            coefWrOrder <= (t < 4) ? 3'h0 : 3'h1;
            coefWrI <= 16'h4000;
        end
        @(posedge clk_sys);
        coefWrEn <= 1'b0;
        rebuild(1'b0, 1'b0);
        sweep();
        write_prescale(4'hE);
        sweep();
        rebuild(1'b0, 1'b1);
        sweep();
        write_prescale(4'h4);
        rebuild(1'b1, 1'b1);
        sweep();
        write_prescale(4'hF);
        sweep();
        predistortionEnable <= 1'b0;
        sweep();
        report_and_stop();
    end

    initial
    begin
        repeat (60000) @(posedge clk_sys);
        errCount++;
        report_and_stop();
    end
endmodule
`default_nettype wire
